// file: hdl/flp_pkg.sv
package flp_pkg;

	// ************************************************************
	// Timebase
	// ************************************************************
	localparam int CLK_PERIOD_PS = 25000;
	localparam int US_PS         = 1000000;
	localparam int CYC_PER_US    = US_PS / CLK_PERIOD_PS;
	localparam int INT_STEP_PS   = 31250;
	localparam int INT_FIXED_US  = 9;
	localparam int INT_FIXED_CYC = INT_FIXED_US * CYC_PER_US;
	localparam int TIME_W        = 24;
	localparam int APB_AW        = 10;

	// ************************************************************
	// Register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [7:0] IDX_A_CONNECT   = 8'h30;
	localparam logic [7:0] IDX_A_PULSES    = 8'h31;
	localparam logic [7:0] IDX_B_CONNECT   = 8'h35;
	localparam logic [7:0] IDX_B_PULSES    = 8'h36;
	localparam logic [7:0] IDX_PERIOD_HIGH = 8'h37;
	localparam logic [7:0] IDX_A_INTEG     = 8'h39;
	localparam logic [7:0] IDX_B_INTEG     = 8'h3b;
	localparam logic [7:0] IDX_A_FLOAT_LED = 8'h3e;
	localparam logic [7:0] IDX_B_FLOAT_LED = 8'h3f;
	localparam logic [7:0] IDX_SIGNS       = 8'h58;
	localparam logic [7:0] IDX_FIRE_MASKS  = 8'h5a;
	localparam logic [7:0] IDX_CONTROL     = 8'h70;
	localparam logic [7:0] IDX_STATUS      = 8'h71;

	localparam logic [15:0] REG_RESET = 16'h0000;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CONNECT_LSB    = 8;
	localparam int DUMP_OFF_LSB   = 0;
	localparam int PULSES_LSB     = 8;
	localparam int PERIOD_LSB     = 0;
	localparam int PERIOD_HI_A    = 0;
	localparam int PERIOD_HI_B    = 8;
	localparam int INT_WIDTH_LSB  = 11;
	localparam int INT_START_LSB  = 0;
	localparam int FLT_WIDTH_LSB  = 8;
	localparam int FLT_OFF_LSB    = 0;
	localparam int LED_SELECT_LSB = 14;
	localparam int SIGN12_A_LSB   = 1;
	localparam int SIGN34_A_LSB   = 8;
	localparam int SIGN12_B_LSB   = 5;
	localparam int SIGN34_B_LSB   = 10;
	localparam int FIRE_A_LSB     = 8;
	localparam int FIRE_B_LSB     = 12;
	localparam int CTRL_START     = 0;
	localparam int CTRL_SLOT_B    = 1;
	localparam int CTRL_AMBIENT   = 2;
	localparam int STAT_BUSY      = 0;
	localparam int STAT_DONE      = 1;
	localparam int STAT_INDEX_LSB = 8;

	localparam logic [7:0] AMBIENT_PULSES = 8'h02;

	typedef enum logic [1:0]
	{
		FLP_IDLE   = 2'b00,
		FLP_RUN    = 2'b01,
		FLP_FINISH = 2'b11
	} flp_state_e;

endpackage

// file: hdl/flp_win_if.sv
`timescale 1ns/1ps
interface flp_win_if;
	import flp_pkg::*;
	logic [TIME_W-1:0] now;
	logic [TIME_W-1:0] base;
	logic [TIME_W-1:0] startCyc;
	logic [TIME_W-1:0] widthCyc;
	logic              active;
	logic              lastCycle;

	modport client (output now, output base, output startCyc, output widthCyc, input active, input lastCycle);
	modport window (input now, input base, input startCyc, input widthCyc, output active, output lastCycle);
endinterface

// file: hdl/flp_window.sv
`timescale 1ns/1ps
module flp_window
	import flp_pkg::*;
(
	flp_win_if.window w
);
	logic [TIME_W-1:0] openAt;
	logic [TIME_W-1:0] closeAt;

	always_comb
	begin
		openAt      = w.base + w.startCyc;
		closeAt     = openAt + w.widthCyc;
		w.active    = (w.now >= openAt) && (w.now < closeAt);
		w.lastCycle = (w.widthCyc != '0) && (w.now == closeAt - TIME_W'(1));
	end
endmodule

// file: hdl/flp_pulse_select.sv
`timescale 1ns/1ps
module flp_pulse_select
	import flp_pkg::*;
(
	input  wire logic [1:0] position,
	input  wire logic [3:0] fireMask,
	input  wire logic [1:0] firstPairSign,
	input  wire logic [1:0] secondPairSign,
	input  wire logic       ambientMode,
	output logic            fire,
	output logic            subtract
);
	logic [1:0] pairSign;

	always_comb
	begin
		pairSign = position[1] ? secondPairSign : firstPairSign;
		if (ambientMode)
		begin
			// Dark pulses only: first pulse subtracted, second added
			fire     = 1'b0;
			subtract = ~position[0];
		end
		else
		begin
			fire     = ~fireMask[position];
			// High field bit signs the first pulse of the pair, low bit the second
			subtract = position[0] ? pairSign[0] : pairSign[1];
		end
	end
endmodule

// file: hdl/flp_float_led_timing.sv
// Notes on behaviour
// - Connect window lasts the slot's 5-bit connect time in microseconds.
// - Integrator start counts in 31.25 ns steps; software picks its value.
// - A fixed 9 us is added before every integration window opens.
// - Each float-mode LED pulse lasts the 5-bit pulse width in microseconds.
// - First LED pulse sits at the slot's 8-bit float LED offset.
// - LED fires only where its 4-bit mask bit is zero, bit0 first.
// - Negative integration phase spans the whole window of a subtracted pulse; integration is timed from its own start field, not the connect window.
// - Signs 2 and 1 add pulses two and three, subtract one and four.
// - All float intervals equal; LED lit by the fire mask alone, whatever the pulse's sign.
// - Ambient mode: two dark pulses, first subtracted, second added.
// - 10-bit float period in microseconds spaces every later pulse.
// - First-pair sign 2 subtracts pulse one and adds pulse two.
// - Second-pair sign 1 adds pulse three and subtracts pulse four.
`timescale 1ns/1ps
module flp_float_led_timing
	import flp_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   ledDrive,
	output logic [1:0]             ledSelect,
	output logic                   pdConnect,
	output logic                   integrate,
	output logic                   integrateSubtract,
	output logic                   resultStrobe,
	output logic                   resultSubtract,
	output logic                   slotB,
	output logic                   busy
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed
	{
		logic [15:0]       aConnect;
		logic [15:0]       aPulses;
		logic [15:0]       bConnect;
		logic [15:0]       bPulses;
		logic [15:0]       periodHigh;
		logic [15:0]       aInteg;
		logic [15:0]       bInteg;
		logic [15:0]       aFloatLed;
		logic [15:0]       bFloatLed;
		logic [15:0]       signs;
		logic [15:0]       fireMasks;
		logic              slotB;
		logic              ambient;
		flp_state_e        state;
		logic              done;
		logic [TIME_W-1:0] now;
		logic [TIME_W-1:0] base;
		logic [7:0]        index;
		logic              led;
		logic [1:0]        ledSel;
		logic              connect;
		logic              integ;
		logic              sub;
		logic              resStrobe;
		logic              resSub;
		logic [31:0]       rdata;
		logic              slvErr;
	} flp_regs_s;

	flp_regs_s r;
	flp_regs_s next_r;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [TIME_W-1:0] usToCyc(input logic [9:0] us);
		return TIME_W'(us) * TIME_W'(CYC_PER_US);
	endfunction

	// Rounded up so the window never opens before the programmed time
	function automatic logic [TIME_W-1:0] stepToCyc(input logic [10:0] steps);
		logic [31:0] ps;
		ps = 32'(steps) * 32'(INT_STEP_PS) + 32'(CLK_PERIOD_PS - 1);
		return TIME_W'(ps / 32'(CLK_PERIOD_PS));
	endfunction

	function automatic logic isMapped(input logic [7:0] idx);
		return idx inside {IDX_A_CONNECT, IDX_A_PULSES, IDX_B_CONNECT, IDX_B_PULSES, IDX_PERIOD_HIGH,
			IDX_A_INTEG, IDX_B_INTEG, IDX_A_FLOAT_LED, IDX_B_FLOAT_LED, IDX_SIGNS, IDX_FIRE_MASKS,
			IDX_CONTROL, IDX_STATUS};
	endfunction

	function automatic logic [TIME_W-1:0] maxTime(input logic [TIME_W-1:0] a, input logic [TIME_W-1:0] b);
		return (a > b) ? a : b;
	endfunction

	// ************************************************************
	// Selected slot configuration
	// ************************************************************
	logic [15:0]       selConnect;
	logic [15:0]       selPulses;
	logic [15:0]       selInteg;
	logic [15:0]       selFloat;
	logic [1:0]        selPeriodHigh;
	logic [1:0]        selSign12;
	logic [1:0]        selSign34;
	logic [3:0]        selMask;
	logic [7:0]        pulseTotal;
	logic [TIME_W-1:0] periodCyc;
	logic [TIME_W-1:0] pulseEnd;
	logic [TIME_W-1:0] lastRel;

	flp_win_if connWin ();
	flp_win_if ledWin ();
	flp_win_if intWin ();

	logic fire;
	logic subtract;

	always_comb
	begin
		selConnect    = r.slotB ? r.bConnect : r.aConnect;
		selPulses     = r.slotB ? r.bPulses : r.aPulses;
		selInteg      = r.slotB ? r.bInteg : r.aInteg;
		selFloat      = r.slotB ? r.bFloatLed : r.aFloatLed;
		selPeriodHigh = r.slotB ? r.periodHigh[PERIOD_HI_B +: 2] : r.periodHigh[PERIOD_HI_A +: 2];
		selSign12     = r.slotB ? r.signs[SIGN12_B_LSB +: 2] : r.signs[SIGN12_A_LSB +: 2];
		selSign34     = r.slotB ? r.signs[SIGN34_B_LSB +: 2] : r.signs[SIGN34_A_LSB +: 2];
		selMask       = r.slotB ? r.fireMasks[FIRE_B_LSB +: 4] : r.fireMasks[FIRE_A_LSB +: 4];
		// Ambient mode always uses exactly two pulses
		pulseTotal    = r.ambient ? AMBIENT_PULSES : selPulses[PULSES_LSB +: 8];
		periodCyc     = usToCyc({selPeriodHigh, selPulses[PERIOD_LSB +: 8]});
	end

	// ************************************************************
	// Windows, all relative to the current pulse's base time
	// ************************************************************
	always_comb
	begin
		connWin.now      = r.now;
		connWin.base     = r.base;
		connWin.startCyc = usToCyc({2'b00, selConnect[DUMP_OFF_LSB +: 8]});
		connWin.widthCyc = usToCyc({5'b00000, selConnect[CONNECT_LSB +: 5]});
		ledWin.now       = r.now;
		ledWin.base      = r.base;
		ledWin.startCyc  = usToCyc({2'b00, selFloat[FLT_OFF_LSB +: 8]});
		ledWin.widthCyc  = usToCyc({5'b00000, selFloat[FLT_WIDTH_LSB +: 5]});
		intWin.now       = r.now;
		intWin.base      = r.base;
		// Fixed lead added ahead of the programmed start
		intWin.startCyc  = stepToCyc(selInteg[INT_START_LSB +: 11])
			+ TIME_W'(INT_FIXED_CYC);
		intWin.widthCyc  = usToCyc({5'b00000, selInteg[INT_WIDTH_LSB +: 5]});
	end

	flp_window uConnWin
	(
		.w (connWin.window)
	);

	flp_window uLedWin
	(
		.w (ledWin.window)
	);

	flp_window uIntWin
	(
		.w (intWin.window)
	);

	// Pulse ends when its latest window closes; every pulse reuses the same offsets
	always_comb
	begin
		pulseEnd = maxTime(connWin.startCyc + connWin.widthCyc,
			maxTime(ledWin.startCyc + ledWin.widthCyc, intWin.startCyc + intWin.widthCyc));
		if (pulseEnd == '0)
		begin
			pulseEnd = TIME_W'(1);
		end
		lastRel = pulseEnd - TIME_W'(1);
	end

	flp_pulse_select uSelect
	(
		.position       (r.index[1:0]),
		.fireMask       (selMask),
		.firstPairSign  (selSign12),
		.secondPairSign (selSign34),
		.ambientMode    (r.ambient),
		.fire           (fire),
		.subtract       (subtract)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	logic       setupPhase;
	logic       accessPhase;
	logic [7:0] regIdx;

	always_comb
	begin
		next_r      = r;
		setupPhase  = psel & ~penable;
		accessPhase = psel & penable;
		regIdx      = paddr[9:2];

		// Read data and error are captured in the setup cycle
		if (setupPhase)
		begin
			next_r.slvErr = ~isMapped(regIdx);
			unique case (regIdx)
				IDX_A_CONNECT:   next_r.rdata = {16'h0000, r.aConnect};
				IDX_A_PULSES:    next_r.rdata = {16'h0000, r.aPulses};
				IDX_B_CONNECT:   next_r.rdata = {16'h0000, r.bConnect};
				IDX_B_PULSES:    next_r.rdata = {16'h0000, r.bPulses};
				IDX_PERIOD_HIGH: next_r.rdata = {16'h0000, r.periodHigh};
				IDX_A_INTEG:     next_r.rdata = {16'h0000, r.aInteg};
				IDX_B_INTEG:     next_r.rdata = {16'h0000, r.bInteg};
				IDX_A_FLOAT_LED: next_r.rdata = {16'h0000, r.aFloatLed};
				IDX_B_FLOAT_LED: next_r.rdata = {16'h0000, r.bFloatLed};
				IDX_SIGNS:       next_r.rdata = {16'h0000, r.signs};
				IDX_FIRE_MASKS:  next_r.rdata = {16'h0000, r.fireMasks};
				IDX_CONTROL:     next_r.rdata = {29'h0, r.ambient, r.slotB, 1'b0};
				IDX_STATUS:      next_r.rdata = {16'h0000, r.index, 6'h00, r.done, r.state != FLP_IDLE};
				default:         next_r.rdata = 32'h0000_0000;
			endcase
		end

		if (accessPhase && pwrite)
		begin
			unique case (regIdx)
				IDX_A_CONNECT:   next_r.aConnect = pwdata[15:0];
				IDX_A_PULSES:    next_r.aPulses = pwdata[15:0];
				IDX_B_CONNECT:   next_r.bConnect = pwdata[15:0];
				IDX_B_PULSES:    next_r.bPulses = pwdata[15:0];
				IDX_PERIOD_HIGH: next_r.periodHigh = pwdata[15:0];
				IDX_A_INTEG:     next_r.aInteg = pwdata[15:0];
				IDX_B_INTEG:     next_r.bInteg = pwdata[15:0];
				IDX_A_FLOAT_LED: next_r.aFloatLed = pwdata[15:0];
				IDX_B_FLOAT_LED: next_r.bFloatLed = pwdata[15:0];
				IDX_SIGNS:       next_r.signs = pwdata[15:0];
				IDX_FIRE_MASKS:  next_r.fireMasks = pwdata[15:0];
				IDX_CONTROL:
				begin
					// A start while a sequence runs is ignored
					if (pwdata[CTRL_START] && r.state == FLP_IDLE)
					begin
						next_r.slotB   = pwdata[CTRL_SLOT_B];
						next_r.ambient = pwdata[CTRL_AMBIENT];
						next_r.state   = FLP_RUN;
						next_r.done    = 1'b0;
						next_r.now     = '0;
						next_r.base    = '0;
						next_r.index   = 8'h00;
					end
				end
				default:
				begin
				end
			endcase
		end

		// ************************************************************
		// Pulse sequencer
		// ************************************************************
		next_r.resStrobe = 1'b0;
		unique case (r.state)
			FLP_IDLE:
			begin
				next_r.led     = 1'b0;
				next_r.connect = 1'b0;
				next_r.integ   = 1'b0;
				next_r.sub     = 1'b0;
			end
			FLP_RUN:
			begin
				next_r.now     = r.now + TIME_W'(1);
				next_r.ledSel  = selFloat[LED_SELECT_LSB +: 2];
				next_r.led     = ledWin.active & fire;
				next_r.connect = connWin.active;
				next_r.integ   = intWin.active;
				next_r.sub     = subtract;
				if (intWin.lastCycle)
				begin
					next_r.resStrobe = 1'b1;
					next_r.resSub    = subtract;
				end
				if (pulseTotal == 8'h00)
				begin
					next_r.state = FLP_FINISH;
				end
				else if (r.now == r.base + lastRel)
				begin
					if (r.index + 8'h01 == pulseTotal)
					begin
						next_r.state = FLP_FINISH;
					end
					else
					begin
						// Every pulse after the first is one float period later
						next_r.index = r.index + 8'h01;
						next_r.base  = r.base + periodCyc;
					end
				end
			end
			FLP_FINISH:
			begin
				next_r.state   = FLP_IDLE;
				next_r.done    = 1'b1;
				next_r.led     = 1'b0;
				next_r.connect = 1'b0;
				next_r.integ   = 1'b0;
				next_r.sub     = 1'b0;
			end
			default:
			begin
				next_r.state = FLP_IDLE;
			end
		endcase
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			r            <= '0;
			r.aConnect   <= REG_RESET;
			r.aPulses    <= REG_RESET;
			r.bConnect   <= REG_RESET;
			r.bPulses    <= REG_RESET;
			r.periodHigh <= REG_RESET;
			r.aInteg     <= REG_RESET;
			r.bInteg     <= REG_RESET;
			r.aFloatLed  <= REG_RESET;
			r.bFloatLed  <= REG_RESET;
			r.signs      <= REG_RESET;
			r.fireMasks  <= REG_RESET;
			r.state      <= FLP_IDLE;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata            = r.rdata;
	assign pready            = 1'b1;
	assign pslverr           = psel & penable & r.slvErr;
	assign ledDrive          = r.led;
	assign ledSelect         = r.ledSel;
	assign pdConnect         = r.connect;
	assign integrate         = r.integ;
	assign integrateSubtract = r.sub;
	assign resultStrobe      = r.resStrobe;
	assign resultSubtract    = r.resSub;
	assign slotB             = r.slotB;
	assign busy              = r.state != FLP_IDLE;

endmodule

// file: verification/flp_timing_assertions.sv
`timescale 1ns/1ps
module flp_timing_assertions
	import flp_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              nrst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              ledDrive,
	input wire logic [1:0]        ledSelect,
	input wire logic              pdConnect,
	input wire logic              integrate,
	input wire logic              integrateSubtract,
	input wire logic              resultStrobe,
	input wire logic              resultSubtract,
	input wire logic              slotB,
	input wire logic              busy
);
	logic [4:0] conA, conB, ledA, ledB, intA, intB;
	logic       amb;
	int         runC, runL, runI;
	wire logic       wr = psel && penable && pwrite;
	wire logic [7:0] ix = paddr[9:2];

	// Shadow the widths from the bus so lengths can be judged exactly
	always_ff @(posedge clk_sys)
	begin
		runC <= pdConnect ? runC + 1 : 0;
		runL <= ledDrive ? runL + 1 : 0;
		runI <= integrate ? runI + 1 : 0;
		if (!nrst)
			{conA, conB, ledA, ledB, intA, intB, amb} <= '0;
		else if (wr)
		begin
			if (ix == IDX_A_CONNECT) conA <= pwdata[12:8];
			if (ix == IDX_B_CONNECT) conB <= pwdata[12:8];
			if (ix == IDX_A_FLOAT_LED) ledA <= pwdata[12:8];
			if (ix == IDX_B_FLOAT_LED) ledB <= pwdata[12:8];
			if (ix == IDX_A_INTEG) intA <= pwdata[15:11];
			if (ix == IDX_B_INTEG) intB <= pwdata[15:11];
			if (ix == IDX_CONTROL && pwdata[0] && !busy) amb <= pwdata[2];
		end
	end

	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	AST_CONNECT_LEN: assert property (
		$fell(pdConnect) |-> runC == (slotB ? conB : conA) * CYC_PER_US) else $error("connect window length wrong");
	AST_LED_LEN: assert property (
		$fell(ledDrive) |-> runL == (slotB ? ledB : ledA) * CYC_PER_US) else $error("LED pulse length wrong");
	AST_INT_LEN: assert property (
		$fell(integrate) |-> runI == (slotB ? intB : intA) * CYC_PER_US) else $error("integration length wrong");
	// Strobe marks the last integrating cycle, so it leads the falling edge by one
	AST_STROBE_AT_END: assert property (
		$past(resultStrobe) == $fell(integrate)) else $error("result strobe not at window end");
	AST_SIGN_HELD: assert property (
		integrate && $past(integrate) |-> $stable(integrateSubtract)) else $error("sign changed inside window");
	AST_RESULT_SIGN: assert property (
		resultStrobe |-> resultSubtract == $past(integrateSubtract)) else $error("result sign differs");
	AST_AMBIENT_DARK: assert property (
		amb && busy |-> !ledDrive) else $error("LED lit in ambient mode");
	AST_WIN_IN_RUN: assert property (
		ledDrive || pdConnect || integrate |-> busy) else $error("window outside sequence");

	cover property ($fell(busy) && slotB);
	cover property (resultStrobe && resultSubtract);
	cover property (amb && $fell(busy));
endmodule

bind flp_float_led_timing flp_timing_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ledDrive(ledDrive), .ledSelect(ledSelect), .pdConnect(pdConnect), .integrate(integrate),
	.integrateSubtract(integrateSubtract), .resultStrobe(resultStrobe), .resultSubtract(resultSubtract),
	.slotB(slotB), .busy(busy));

// file: verification/flp_front_end_model.sv
`timescale 1ns/1ps
module flp_front_end_model
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic clr,
	input wire logic busy,
	input wire logic ledDrive,
	input wire logic pdConnect,
	input wire logic integrate,
	input wire logic resultStrobe,
	input wire logic resultSubtract
);
	int          tc, firstLed, firstCon, firstInt, lastInt, ledCyc, conCyc, nStrobe;
	logic [15:0] signs, lit;
	logic        seen, intD;

	// Times are counted from the first cycle of the sequence
	always_ff @(posedge clk_sys)
	begin
		intD <= integrate;
		if (!nrst || clr)
		begin
			{tc, ledCyc, conCyc, nStrobe, lastInt} <= '0;
			{firstLed, firstCon, firstInt} <= '1;
			{signs, lit, seen} <= '0;
		end
		else
		begin
			tc <= busy ? tc + 1 : 0;
			if (ledDrive)
			begin
				ledCyc <= ledCyc + 1;
				seen <= 1'b1;
				if (firstLed < 0) firstLed <= tc;
			end
			if (pdConnect)
			begin
				conCyc <= conCyc + 1;
				if (firstCon < 0) firstCon <= tc;
			end
			if (integrate && !intD)
			begin
				lastInt <= tc;
				if (firstInt < 0) firstInt <= tc;
			end
			// Each result is booked with its sign and whether light was present
			if (resultStrobe)
			begin
				nStrobe <= nStrobe + 1;
				signs <= {signs[14:0], resultSubtract};
				lit <= {lit[14:0], seen};
				seen <= 1'b0;
			end
		end
	end
endmodule

// file: verification/test_float_led_pulse_timing.sv
`timescale 1ns/1ps
module test_float_led_pulse_timing
	import flp_pkg::*;
;
	logic              clk_sys, nrst, psel, penable, pwrite, clr;
	logic [APB_AW-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic              pready, pslverr, ledDrive, pdConnect, integrate, integrateSubtract;
	logic              resultStrobe, resultSubtract, slotB, busy;
	logic [1:0]        ledSelect;
	int                n_fail, n_compared;

	flp_float_led_timing DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ledDrive(ledDrive),
		.ledSelect(ledSelect), .pdConnect(pdConnect), .integrate(integrate), .integrateSubtract(integrateSubtract),
		.resultStrobe(resultStrobe), .resultSubtract(resultSubtract), .slotB(slotB), .busy(busy));
	flp_front_end_model u_fe (.clk_sys(clk_sys), .nrst(nrst), .clr(clr), .busy(busy), .ledDrive(ledDrive),
		.pdConnect(pdConnect), .integrate(integrate), .resultStrobe(resultStrobe), .resultSubtract(resultSubtract));

	always #12.5 clk_sys = ~clk_sys;

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic end_of_test();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Upper write bits are driven high so a leak into storage shows
	task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {16'hffff, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			chk(32'h0, 32'h1);
			end_of_test();
		end
	endtask

	task automatic reg_test();
		logic [7:0]  tab [11];
		logic [31:0] q;
		logic        e;
		tab = '{IDX_A_CONNECT, IDX_A_PULSES, IDX_B_CONNECT, IDX_B_PULSES, IDX_A_INTEG, IDX_B_INTEG,
			IDX_A_FLOAT_LED, IDX_B_FLOAT_LED, IDX_FIRE_MASKS, IDX_PERIOD_HIGH, IDX_SIGNS};
		foreach (tab[i])
		begin
			apb(1'b0, tab[i], 16'h0, q, e);
			chk(q, 32'h0);
			apb(1'b1, tab[i], 16'ha5c3 ^ 16'(i), q, e);
			apb(1'b0, tab[i], 16'h0, q, e);
			chk(q, {16'h0, 16'ha5c3 ^ 16'(i)});
			chk({31'h0, e}, 32'h0);
		end
		// Period MSBs back to zero: the sequence runs assume a 20 us period
		apb(1'b1, IDX_PERIOD_HIGH, 16'h0, q, e);
		apb(1'b1, 8'h00, 16'h1234, q, e);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 8'h00, 16'h0, q, e);
		chk(q, 32'h0);
	endtask

	// Connect 2 us at 14 us, integrate 3 us from 10.75 us (1.75 us start plus fixed 9 us), LED 2 us at 3 us, period 20 us
	task automatic run_seq(input logic sb, input logic [7:0] np, input logic [3:0] mk, input logic amb,
		input logic [15:0] es, input logic [15:0] el, input int fl);
		logic [31:0] q;
		logic        e;
		int          n, k;
		k = amb ? 2 : int'(np);
		apb(1'b1, sb ? IDX_B_CONNECT : IDX_A_CONNECT, 16'h020e, q, e);
		apb(1'b1, sb ? IDX_B_PULSES : IDX_A_PULSES, {np, 8'h14}, q, e);
		apb(1'b1, sb ? IDX_B_INTEG : IDX_A_INTEG, 16'h1838, q, e);
		apb(1'b1, sb ? IDX_B_FLOAT_LED : IDX_A_FLOAT_LED, 16'h4203, q, e);
		apb(1'b1, IDX_SIGNS, 16'h0544, q, e);
		clr <= 1'b1;
		apb(1'b1, IDX_FIRE_MASKS, {mk, mk, 8'h00}, q, e);
		clr <= 1'b0;
		apb(1'b1, IDX_CONTROL, {13'h0, amb, sb, 1'b1}, q, e);
		@(negedge clk_sys);
		chk({31'h0, busy}, 32'h1);
		n = 0;
		while (busy === 1'b1 && n < 20000)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 20000)
		begin
			chk(32'h0, 32'h1);
			end_of_test();
		end
		chk(u_fe.nStrobe, k);
		chk(u_fe.signs, es);
		chk(u_fe.lit, el);
		chk(u_fe.ledCyc, $countones(el) * 2 * CYC_PER_US);
		chk(u_fe.conCyc, k * 2 * CYC_PER_US);
		chk(u_fe.firstLed, fl);
		chk({30'h0, ledSelect}, 32'h1);
		chk({31'h0, slotB}, {31'h0, sb});
		apb(1'b0, IDX_STATUS, 16'h0, q, e);
		chk(q, {16'h0, 8'(k > 0 ? k - 1 : 0), 8'h02});
		apb(1'b0, IDX_CONTROL, 16'h0, q, e);
		chk(q, {29'h0, amb, sb, 1'b0});
		if (k > 0)
		begin
			chk(u_fe.firstInt, (56 * INT_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + INT_FIXED_CYC + 1);
			chk(u_fe.firstCon, 14 * CYC_PER_US + 1);
			chk(u_fe.lastInt - u_fe.firstInt, (k - 1) * 20 * CYC_PER_US);
		end
	endtask

	initial
	begin
		{clk_sys, nrst, psel, penable, pwrite, clr, paddr, pwdata} = '0;
		n_fail = 0;
		n_compared = 0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		reg_test();
		run_seq(1'b0, 8'd4, 4'h9, 1'b0, 16'h9, 16'h6, 921);
		run_seq(1'b1, 8'd8, 4'h9, 1'b0, 16'h99, 16'h66, 921);
		run_seq(1'b0, 8'd4, 4'h6, 1'b0, 16'h9, 16'h9, 121);
		run_seq(1'b0, 8'd4, 4'h9, 1'b1, 16'h2, 16'h0, -1);
		run_seq(1'b0, 8'd0, 4'h9, 1'b0, 16'h0, 16'h0, -1);
		end_of_test();
	end
endmodule
